/* File: pkg/ctm_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts of the core timer unit.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH

// register byte offsets, word aligned
`define CTM_ADDR_W        16
`define CTM_OFF_TIME_LO   16'h0000
`define CTM_OFF_TIME_HI   16'h0004
`define CTM_OFF_CMP_LO    16'h0008
`define CTM_OFF_CMP_HI    16'h000c
`define CTM_OFF_SRST      16'h0ff0
`define CTM_OFF_CTL       16'h0ff8
`define CTM_OFF_MSW       16'h0ffc
`define CTM_OFF_SSW       16'hd000

// control field positions
`define CTM_CTL_W         4
`define CTM_CTL_PAUSE     0
`define CTM_CTL_CLR       1
`define CTM_CTL_SRC       2
`define CTM_CTL_HALT_ON_DEBUG      3

// soft-reset key and flag position
`define CTM_SRST_KEY      32'h80000a5f
`define CTM_SRST_BIT      31

// reset values
`define CTM_CMP_RST       64'hffffffffffffffff
`define CTM_CTL_RST       4'h0

// local interrupt source numbers
`define CTM_SRC_N         19
`define CTM_SRC_SSW       1
`define CTM_SRC_MSW       3
`define CTM_SRC_TMR       7

// timing
`define CTM_CLK_NS        20
`define CTM_CORE_RST_NS   200
`define CTM_CORE_RST_CYC  ((`CTM_CORE_RST_NS + `CTM_CLK_NS - 1) / `CTM_CLK_NS)
`define CTM_AON_DIV       2
`define CTM_DIV_W         16
`define CTM_HOLD_W        16

`endif

/* File: pkg/ctm_pkg.sv */
/*
 * Types of the core timer unit: state records of each module and the reset FSM states.
 * Assumes ctm_cfg.svh is on the include path.
 */
`default_nettype none
`include "ctm_cfg.svh"

package ctm_pkg;

  typedef struct packed {
    logic [63:0]            count;
    logic [63:0]            cmp;
    logic [`CTM_CTL_W-1:0]  ctl;
    logic                   msw;
    logic                   ssw;
    logic                   rst_req;
    logic                   tmr_irq;
    logic [31:0]            rdata;
    logic                   rvalid;
  } ctm_dev_state_t;

  typedef struct packed {
    logic                   sync1;
    logic                   sync2;
    logic                   sync3;
    logic [`CTM_DIV_W-1:0]  div;
    logic                   tick;
  } ctm_tick_state_t;

  typedef enum logic [2:0] {
    CTM_ST_RUN  = 3'b001,
    CTM_ST_HOLD = 3'b010,
    CTM_ST_WAIT = 3'b100
  } ctm_soc_st_t;

  typedef struct packed {
    ctm_soc_st_t             st;
    logic [`CTM_HOLD_W-1:0]  cnt;
    logic                    tmr_prev;
    logic                    tmr_pend;
    logic                    msw;
    logic                    ssw;
  } ctm_soc_state_t;

endpackage

`default_nettype wire

/* File: pkg/ctm_link_if.sv */
/*
 * Link between the core timer unit and the SoC side (interrupt controller and reset logic).
 * Assumes both ends run on the same clock; the testbench instantiates it and joins the ends.
 */
`default_nettype none
`include "ctm_cfg.svh"

interface ctm_link_if;
  logic [`CTM_SRC_N-1:0] irq_src;
  logic                  sysrstreq;
  logic                  core_rst_n;
  logic                  por_rst_n;

  modport dev (
    output irq_src,
    output sysrstreq,
    input  core_rst_n,
    input  por_rst_n
  );

  modport soc (
    input  irq_src,
    input  sysrstreq,
    output core_rst_n,
    output por_rst_n
  );
endinterface

`default_nettype wire

/* File: verilog/ctm_tick_gen.sv */
/*
 * Tick enable for the time counter: either a divided always-on rate or the rising edges
 * of an external toggle pin, chosen by the tick source select bit.
 * Assumes the toggle pin is asynchronous to i_mclk and toggles slower than half its rate.
 */
`default_nettype none
`include "ctm_cfg.svh"

module ctm_tick_gen
  import ctm_pkg::*;
#(
  parameter int AON_DIV = `CTM_AON_DIV
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // control
  input  wire logic i_src_aon,
  input  wire logic i_toggle_pin,
  // tick
  output logic      o_tick
);

  localparam logic [`CTM_DIV_W-1:0] DIV_LAST = `CTM_DIV_W'(AON_DIV - 1);

  generate
    if (AON_DIV < 1 || AON_DIV > (1 << `CTM_DIV_W)) begin : g_bad_div
      $error("ctm_tick_gen: AON_DIV out of range");
    end
  endgenerate

  ctm_tick_state_t q_reg;
  ctm_tick_state_t q_next;

  always_comb begin
    q_next       = q_reg;
    q_next.sync1 = i_toggle_pin;
    q_next.sync2 = q_reg.sync1;
    q_next.sync3 = q_reg.sync2;
    q_next.tick  = 1'b0;
    if (i_src_aon) begin
      if (q_reg.div == DIV_LAST) begin
        q_next.div  = '0;
        q_next.tick = 1'b1;
      end else begin
        q_next.div = q_reg.div + `CTM_DIV_W'(1);
      end
    end else begin
      q_next.div  = '0;
      // one tick per rising edge of the toggle input
      q_next.tick = q_reg.sync2 & ~q_reg.sync3;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_tick = q_reg.tick;

endmodule

`default_nettype wire

/* File: verilog/ctm_timer_dev.sv */
/*
 * Core timer unit: 64-bit time counter and compare, control bits, machine and
 * supervisor software interrupts and a keyed soft-reset request.
 * Assumes word-aligned 32-bit register accesses on one clock, and an SoC end
 * on the link that answers the soft-reset request with the core reset.
 */
// How it works
// - timer interrupt while count exceeds 64-bit compare
// - clear-on-match zeroes count after exceeding compare
// - otherwise count keeps running; software rewrites compare
// - halt-on-debug lets debug stop-time freeze count
// - tick source: always-on rate or toggle input
// - pause bit stops the counter
// - clear-on-match gives a one-cycle interrupt pulse
// - software interrupt bit zero only, write sets/clears
// - soft-reset flag set only by exact key
// - soft-reset flag cleared only by reset
// - pending soft-reset drives active-high request output
// - SoC answers with core reset, not power-on
// - machine software source 3, supervisor software source 1, timer source 7
// - counter counts toggle-input edges from reset unless paused
// - compare halves reset to all ones
// - software uses aligned word accesses only
`default_nettype none
`include "ctm_cfg.svh"

module ctm_timer_dev
  import ctm_pkg::*;
#(
  parameter int AON_DIV = `CTM_AON_DIV
) (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  // register port
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [`CTM_ADDR_W-1:0] i_reg_addr,
  input  wire logic [31:0]            i_reg_wdata,
  output logic      [31:0]            o_reg_rdata,
  output logic                        o_reg_rvalid,
  // core debug state
  input  wire logic                   i_dbg_mode,
  input  wire logic                   i_dbg_stoptime,
  // external tick toggle pin
  input  wire logic                   i_tick_toggle,
  // link to the SoC side
  ctm_link_if.dev                     link
);

  localparam ctm_dev_state_t DEV_RST = '{
    count:   64'h0,
    cmp:     `CTM_CMP_RST,
    ctl:     `CTM_CTL_RST,
    msw:     1'b0,
    ssw:     1'b0,
    rst_req: 1'b0,
    tmr_irq: 1'b0,
    rdata:   32'h0,
    rvalid:  1'b0
  };

  ctm_dev_state_t q_reg;
  ctm_dev_state_t q_next;
  logic           rst_n;
  logic           tick;
  logic           gt;
  logic           run;
  logic           halt;

  // the core reset from the SoC resets this unit too
  assign rst_n = i_rst_n & link.core_rst_n;

  ctm_tick_gen #(
    .AON_DIV (AON_DIV)
  ) u_tick (
    .i_mclk       (i_mclk),
    .i_rst_n      (rst_n),
    .i_src_aon    (q_reg.ctl[`CTM_CTL_SRC]),
    .i_toggle_pin (i_tick_toggle),
    .o_tick       (tick)
  );

  always_comb begin
    q_next        = q_reg;
    q_next.rvalid = 1'b0;
    gt   = q_reg.count > q_reg.cmp;
    halt = q_reg.ctl[`CTM_CTL_HALT_ON_DEBUG] & i_dbg_mode & i_dbg_stoptime;
    run  = tick & ~q_reg.ctl[`CTM_CTL_PAUSE] & ~halt;

    if (run) begin
      q_next.count = q_reg.count + 64'h1;
    end
    if (q_reg.ctl[`CTM_CTL_CLR] && gt) begin
      // clearing drops gt next cycle, so the interrupt is one cycle long
      q_next.count = 64'h0;
    end
    q_next.tmr_irq = gt;

    // software writes win over counting
    if (i_reg_wr) begin
      case (i_reg_addr)
        `CTM_OFF_TIME_LO: q_next.count[31:0]  = i_reg_wdata;
        `CTM_OFF_TIME_HI: q_next.count[63:32] = i_reg_wdata;
        `CTM_OFF_CMP_LO:  q_next.cmp[31:0]    = i_reg_wdata;
        `CTM_OFF_CMP_HI:  q_next.cmp[63:32]   = i_reg_wdata;
        `CTM_OFF_CTL:     q_next.ctl          = i_reg_wdata[`CTM_CTL_W-1:0];
        `CTM_OFF_MSW:     q_next.msw          = i_reg_wdata[0];
        `CTM_OFF_SSW:     q_next.ssw          = i_reg_wdata[0];
        `CTM_OFF_SRST: begin
          if (i_reg_wdata == `CTM_SRST_KEY) begin
            q_next.rst_req = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // rst_req has no clearing path besides reset

    if (i_reg_rd) begin
      q_next.rvalid = 1'b1;
      case (i_reg_addr)
        `CTM_OFF_TIME_LO: q_next.rdata = q_reg.count[31:0];
        `CTM_OFF_TIME_HI: q_next.rdata = q_reg.count[63:32];
        `CTM_OFF_CMP_LO:  q_next.rdata = q_reg.cmp[31:0];
        `CTM_OFF_CMP_HI:  q_next.rdata = q_reg.cmp[63:32];
        `CTM_OFF_CTL:     q_next.rdata = {28'h0, q_reg.ctl};
        `CTM_OFF_MSW:     q_next.rdata = {31'h0, q_reg.msw};
        `CTM_OFF_SSW:     q_next.rdata = {31'h0, q_reg.ssw};
        `CTM_OFF_SRST:    q_next.rdata = {q_reg.rst_req, 31'h0};
        default:          q_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!rst_n) begin
      q_reg <= DEV_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_reg_rdata  = q_reg.rdata;
  assign o_reg_rvalid = q_reg.rvalid;

  always_comb begin
    link.irq_src                = '0;
    link.irq_src[`CTM_SRC_SSW]  = q_reg.ssw;
    link.irq_src[`CTM_SRC_MSW]  = q_reg.msw;
    link.irq_src[`CTM_SRC_TMR]  = q_reg.tmr_irq;
  end

  assign link.sysrstreq = q_reg.rst_req;

endmodule

`default_nettype wire

/* File: verilog/ctm_soc_end.sv */
/*
 * SoC end of the core timer link: takes the local interrupt lines into pending
 * state for the core and answers a soft-reset request with a timed core reset.
 * Assumes the same clock as the timer unit; the power-on reset stays released.
 */
`default_nettype none
`include "ctm_cfg.svh"

module ctm_soc_end
  import ctm_pkg::*;
#(
  parameter int HOLD_CYC = `CTM_CORE_RST_CYC
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // interrupt controller side
  input  wire logic i_tmr_edge,
  input  wire logic i_tmr_ack,
  output logic      o_tmr_irq,
  output logic      o_msw_irq,
  output logic      o_ssw_irq,
  // reset status
  output logic      o_rst_busy,
  // link to the timer unit
  ctm_link_if.soc   link
);

  localparam logic [`CTM_HOLD_W-1:0] HOLD_LAST = `CTM_HOLD_W'(HOLD_CYC - 1);

  generate
    if (HOLD_CYC < 1 || HOLD_CYC > (1 << `CTM_HOLD_W)) begin : g_bad_hold
      $error("ctm_soc_end: HOLD_CYC out of range");
    end
  endgenerate

  ctm_soc_state_t q_reg;
  ctm_soc_state_t q_next;
  logic           tmr_in;

  assign tmr_in = link.irq_src[`CTM_SRC_TMR];

  always_comb begin
    q_next          = q_reg;
    q_next.tmr_prev = tmr_in;
    q_next.msw      = link.irq_src[`CTM_SRC_MSW];
    q_next.ssw      = link.irq_src[`CTM_SRC_SSW];
    if (i_tmr_edge) begin
      // edge mode catches the one-cycle pulse; a new edge beats the ack
      if (i_tmr_ack) begin
        q_next.tmr_pend = 1'b0;
      end
      if (tmr_in && !q_reg.tmr_prev) begin
        q_next.tmr_pend = 1'b1;
      end
    end else begin
      q_next.tmr_pend = tmr_in;
    end

    unique case (q_reg.st)
      CTM_ST_RUN: begin
        if (link.sysrstreq) begin
          q_next.st  = CTM_ST_HOLD;
          q_next.cnt = '0;
        end
      end
      CTM_ST_HOLD: begin
        if (q_reg.cnt == HOLD_LAST) begin
          q_next.st = CTM_ST_WAIT;
        end else begin
          q_next.cnt = q_reg.cnt + `CTM_HOLD_W'(1);
        end
      end
      CTM_ST_WAIT: begin
        if (!link.sysrstreq) begin
          q_next.st = CTM_ST_RUN;
        end
      end
      default: q_next.st = CTM_ST_RUN;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      q_reg <= '{st: CTM_ST_RUN, cnt: '0, tmr_prev: 1'b0, tmr_pend: 1'b0,
                 msw: 1'b0, ssw: 1'b0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign link.core_rst_n = (q_reg.st != CTM_ST_HOLD);
  assign link.por_rst_n  = 1'b1;
  assign o_tmr_irq       = q_reg.tmr_pend;
  assign o_msw_irq       = q_reg.msw;
  assign o_ssw_irq       = q_reg.ssw;
  assign o_rst_busy      = (q_reg.st != CTM_ST_RUN);

endmodule

`default_nettype wire

/* File: verif/ctm_link_asserts.sv */
/*
 * Checker on the link between the core timer unit and its SoC end.
 * Assumes one clock and an active-low synchronous reset shared by both ends.
 */
`default_nettype none
`include "ctm_cfg.svh"

module ctm_link_asserts #(
  parameter int HOLD_CYC = 4
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  input  wire logic [`CTM_SRC_N-1:0] irq_src,
  input  wire logic                  sysrstreq,
  input  wire logic                  core_rst_n,
  input  wire logic                  por_rst_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] low_cnt_reg;
  logic [15:0] low_cnt_next;

  // length of the current core reset pulse
  always_comb low_cnt_next = core_rst_n ? 16'h0 : low_cnt_reg + 16'h1;
  always_ff @(posedge i_mclk) low_cnt_reg <= i_rst_n ? low_cnt_next : 16'h0;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_spare_src_zero;
    (irq_src & ~19'h0008a) == 19'h0;
  endproperty
  a_spare_src_zero: assert property (p_spare_src_zero)
    else $error("spare interrupt source raised");

  property p_por_high;
    por_rst_n;
  endproperty
  a_por_high: assert property (p_por_high)
    else $error("power-on reset used");

  property p_req_to_core_rst;
    $rose(sysrstreq) |=> !core_rst_n;
  endproperty
  a_req_to_core_rst: assert property (p_req_to_core_rst)
    else $error("reset request not answered");

  property p_core_rst_cause;
    $fell(core_rst_n) |-> $past(sysrstreq);
  endproperty
  a_core_rst_cause: assert property (p_core_rst_cause)
    else $error("core reset without request");

  property p_req_held;
    sysrstreq && core_rst_n |=> sysrstreq;
  endproperty
  a_req_held: assert property (p_req_held)
    else $error("reset request dropped early");

  property p_rst_clears;
    !core_rst_n |=> !sysrstreq && irq_src == 19'h0;
  endproperty
  a_rst_clears: assert property (p_rst_clears)
    else $error("core reset left unit state");

  property p_hold_len;
    $rose(core_rst_n) |-> low_cnt_reg == 16'(HOLD_CYC);
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("core reset pulse length wrong");

  property p_req_fall_by_rst;
    $fell(sysrstreq) |-> !$past(core_rst_n);
  endproperty
  a_req_fall_by_rst: assert property (p_req_fall_by_rst)
    else $error("reset request cleared without reset");
endmodule

`default_nettype wire

/* File: verif/tb.sv */
/*
 * Testbench joining the core timer unit and its SoC end through the link.
 * Assumes the package, interface and both design modules are compiled first.
 */
`default_nettype none
`include "ctm_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int HOLD = 4;
  logic        i_mclk, i_rst_n, i_reg_wr, i_reg_rd, i_dbg_mode, i_dbg_stoptime;
  logic        i_tick_toggle, i_tmr_edge, o_reg_rvalid, o_tmr_irq, o_msw_irq;
  logic        o_ssw_irq, o_rst_busy, pv, i_tmr_ack;
  logic [15:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, v;
  logic [31:0] exp_q[$];
  int          miscompares, checked, hi_cnt, dbl, k;

  ctm_link_if ctm_link_if_inst ();
  ctm_timer_dev #(.AON_DIV(1)) ctm_timer_dev_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_dbg_mode(i_dbg_mode), .i_dbg_stoptime(i_dbg_stoptime),
    .i_tick_toggle(i_tick_toggle), .link(ctm_link_if_inst));
  ctm_soc_end #(.HOLD_CYC(HOLD)) ctm_soc_end_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_tmr_edge(i_tmr_edge), .i_tmr_ack(i_tmr_ack), .o_tmr_irq(o_tmr_irq),
    .o_msw_irq(o_msw_irq), .o_ssw_irq(o_ssw_irq), .o_rst_busy(o_rst_busy),
    .link(ctm_link_if_inst));
  ctm_link_asserts #(.HOLD_CYC(HOLD)) ctm_link_asserts_inst (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .irq_src(ctm_link_if_inst.irq_src),
    .sysrstreq(ctm_link_if_inst.sysrstreq), .core_rst_n(ctm_link_if_inst.core_rst_n),
    .por_rst_n(ctm_link_if_inst.por_rst_n));

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic end_of_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sig(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one strobe per access, released a cycle later; word-aligned addresses only
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge i_mclk);
    i_reg_wr = w;
    i_reg_rd = !w;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_mclk);
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  always @(negedge i_mclk) begin
    if (o_reg_rvalid && exp_q.size() > 0)
      chk_rd(o_reg_rdata, exp_q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    {i_rst_n, i_reg_wr, i_reg_rd, i_dbg_mode, i_dbg_stoptime} = 5'h0;
    i_tmr_ack = 1'b0;
    {i_tick_toggle, i_tmr_edge, i_reg_addr, i_reg_wdata} = 50'h0;
    miscompares = 0;
    checked = 0;
    v = $urandom(32'h3c31);
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst_n = 1'b1;
    rd(`CTM_OFF_CTL, 32'h0);
    rd(`CTM_OFF_CMP_LO, 32'hffffffff);
    rd(`CTM_OFF_CMP_HI, 32'hffffffff);
    rd(`CTM_OFF_SRST, 32'h0);
    rd(16'h0100, 32'h0);
    v = $urandom;
    wr(`CTM_OFF_CTL, {v[31:4], 4'h4});
    rd(`CTM_OFF_CTL, 32'h4);
    wr(`CTM_OFF_MSW, $urandom | 32'h1);
    wr(`CTM_OFF_SSW, 32'h1);
    idle(2);
    chk_sig(ctm_link_if_inst.irq_src[3], 1'b1);
    chk_sig(o_ssw_irq, 1'b1);
    rd(`CTM_OFF_MSW, 32'h1);
    wr(`CTM_OFF_MSW, $urandom & 32'hfffffffe);
    wr(`CTM_OFF_SSW, 32'h0);
    idle(2);
    chk_sig(o_msw_irq, 1'b0);
    chk_sig(ctm_link_if_inst.irq_src[1], 1'b0);
    wr(`CTM_OFF_CMP_HI, 32'h0);
    wr(`CTM_OFF_TIME_LO, 32'h0);
    wr(`CTM_OFF_CMP_LO, 32'd20);
    idle(30);
    chk_sig(ctm_link_if_inst.irq_src[7], 1'b1);
    chk_sig(o_tmr_irq, 1'b1);
    wr(`CTM_OFF_CMP_LO, 32'hffffffff);
    idle(3);
    chk_sig(ctm_link_if_inst.irq_src[7], 1'b0);
    wr(`CTM_OFF_CTL, 32'h5);
    wr(`CTM_OFF_TIME_LO, 32'h1234);
    idle(10);
    rd(`CTM_OFF_TIME_LO, 32'h1234);
    i_dbg_mode = 1'b1;
    i_dbg_stoptime = 1'b1;
    wr(`CTM_OFF_CTL, 32'hc);
    wr(`CTM_OFF_TIME_LO, 32'h7);
    idle(10);
    rd(`CTM_OFF_TIME_LO, 32'h7);
    i_dbg_mode = 1'b0;
    wr(`CTM_OFF_CTL, 32'h0);
    wr(`CTM_OFF_TIME_LO, 32'h0);
    repeat (3) begin
      i_tick_toggle = 1'b1;
      idle(3);
      i_tick_toggle = 1'b0;
      idle(3);
    end
    idle(4);
    rd(`CTM_OFF_TIME_LO, 32'h3);
    i_tmr_edge = 1'b1;
    wr(`CTM_OFF_CMP_LO, 32'd10);
    wr(`CTM_OFF_CTL, 32'h6);
    {hi_cnt, dbl, pv} = 65'h0;
    repeat (40) begin
      @(negedge i_mclk);
      hi_cnt += int'(ctm_link_if_inst.irq_src[7]);
      dbl += int'(pv & ctm_link_if_inst.irq_src[7]);
      pv = ctm_link_if_inst.irq_src[7];
    end
    chk_sig(hi_cnt >= 2, 1'b1);
    chk_sig(dbl == 0, 1'b1);
    chk_sig(o_tmr_irq, 1'b1);
    wr(`CTM_OFF_CMP_LO, 32'hffffffff);
    i_tmr_ack = 1'b1;
    idle(1);
    i_tmr_ack = 1'b0;
    idle(1);
    chk_sig(o_tmr_irq, 1'b0);
    wr(`CTM_OFF_SRST, 32'h80000a5e);
    rd(`CTM_OFF_SRST, 32'h0);
    wr(`CTM_OFF_SRST, `CTM_SRST_KEY);
    for (k = 0; k < 5 && !o_rst_busy; k++) idle(1);
    chk_sig(o_rst_busy, 1'b1);
    for (k = 0; k < 30 && o_rst_busy; k++) idle(1);
    chk_sig(o_rst_busy, 1'b0);
    rd(`CTM_OFF_SRST, 32'h0);
    rd(`CTM_OFF_CTL, 32'h0);
    idle(3);
    end_of_test();
  end
endmodule

`default_nettype wire
